// [common/sar_defs.svh]
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH
// ***************************************************************
// word, timing and buffer constants
// ***************************************************************
`define SAR_WORD_BITS        16
`define SAR_CLK_NS           25
`define SAR_CONV_MIN_NS      500
`define SAR_CONV_MAX_NS      8800
`define SAR_ACQ_NS           1200
`define SAR_CONV_MIN_CYC     ((`SAR_CONV_MIN_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_CONV_MAX_CYC     (`SAR_CONV_MAX_NS / `SAR_CLK_NS)
`define SAR_ACQ_CYC          ((`SAR_ACQ_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_FIFO_DEPTH       4
`define SAR_RESULT_RESET     16'h0000
`endif

// [common/sar_pkg.sv]
package sar_pkg;
   typedef enum logic [3:0] {
      SAR_IDLE = 4'b0001,
      SAR_CONV = 4'b0010,
      SAR_ACQ  = 4'b0100,
      SAR_READ = 4'b1000
   } sar_state_t;

   typedef enum logic [1:0] {
      SAR_MODE_3W    = 2'b01,
      SAR_MODE_4W    = 2'b10,
      SAR_MODE_CHAIN = 2'b00
   } sar_mode_t;
endpackage

// [core/sar_fifo.sv]
`timescale 1ns/100ps
module sar_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic             ce_i,
   // write side
   input  wire logic             wr_valid_i,
   output logic                  wr_ready_o,
   input  wire logic [WIDTH-1:0] wr_data_i,
   // read side
   output logic                  rd_valid_o,
   input  wire logic             rd_ready_i,
   output logic      [WIDTH-1:0] rd_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic [WIDTH-1:0]            out;
      logic                        vld;
   } sar_fifo_st_t;

   sar_fifo_st_t q, d;
   logic push, pop_mem, load, full;

   // the output register holds one of the words, so it counts toward full
   assign full = (q.cnt + (AW + 1)'(q.vld)) == (AW + 1)'(DEPTH);

   always_comb
   begin
      d       = q;
      push    = wr_valid_i && !full;
      load    = !q.vld || rd_ready_i;
      pop_mem = load && (q.cnt != '0);
      if (push)
      begin
         d.mem[q.wp] = wr_data_i;
         d.wp        = q.wp + 1'b1;
      end
      if (load)
         d.vld = pop_mem;
      if (pop_mem)
      begin
         // read data leaves through a register
         d.out = q.mem[q.rp];
         d.rp  = q.rp + 1'b1;
      end
      d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop_mem);
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         q <= '0;
      else if (ce_i)
         q <= d;
   end

   assign wr_ready_o = !full;
   assign rd_valid_o = q.vld;
   assign rd_data_o  = q.out;

   a_fifo_bound : assert property (@(posedge clk_i) disable iff (reset_i)
      q.cnt <= (AW + 1)'(DEPTH)) else $error("fifo count overflow");
endmodule

// [core/sar_serial.sv]
`timescale 1ns/100ps
`include "sar_defs.svh"
module sar_serial #(
   parameter int WORD_BITS  = `SAR_WORD_BITS,
   parameter int CONV_CYC   = `SAR_CONV_MAX_CYC,
   parameter int FIFO_DEPTH = `SAR_FIFO_DEPTH
) (
   // clock, reset, enable
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 ce_i,
   // converter core side: signed sample words
   input  wire logic                 sample_valid_i,
   output logic                      sample_ready_o,
   input  wire logic [WORD_BITS-1:0] sample_i,
   // device pins
   input  wire logic                 conversion_trigger_i,
   input  wire logic                 sclk_i,
   input  wire logic                 sdi_i,
   output logic                      sdo_o,
   output logic                      sdo_oe_o,
   // status
   output logic                      busy_o
);
   if (WORD_BITS != 16)
   begin : g_bad_width
      $error("word width must be 16");
   end
   if (CONV_CYC < `SAR_CONV_MIN_CYC || CONV_CYC > `SAR_CONV_MAX_CYC)
   begin : g_bad_conv
      $error("conversion count outside bounds");
   end
   if (FIFO_DEPTH < 2)
   begin : g_bad_depth
      $error("buffer depth must be at least 2");
   end

   localparam int CW = $clog2(`SAR_CONV_MAX_CYC + 1);
   localparam int BW = $clog2(WORD_BITS + 1);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [1:0]             cnv_s;
      logic [1:0]             sck_s;
      logic [1:0]             sdi_s;
      logic                   cnv_p;
      logic                   sck_p;
      logic                   sdi_p;
      sar_pkg::sar_state_t    st;
      sar_pkg::sar_mode_t     mode;
      logic [CW-1:0]          cnt;
      logic [BW-1:0]          bits;
      logic [WORD_BITS-1:0]   shreg;
      logic                   sdo;
      logic                   oe;
      logic                   busy;
      logic                   sready;
   } sar_st_t;

   sar_st_t q, d;

   // ***************************************************************
   // buffer between core and shifter
   // ***************************************************************
   logic                 fifo_wr_ready;
   logic                 fifo_vld;
   logic                 fifo_take;
   logic [WORD_BITS-1:0] fifo_data;

   sar_fifo #(
      .WIDTH (WORD_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .ce_i       (ce_i),
      .wr_valid_i (sample_valid_i && q.sready),
      .wr_ready_o (fifo_wr_ready),
      .wr_data_i  (sample_i),
      .rd_valid_o (fifo_vld),
      .rd_ready_i (fifo_take),
      .rd_data_o  (fifo_data)
   );

   // ***************************************************************
   // pin edges and chip select
   // ***************************************************************
   // edge views of the synchronised pins; second stage only
   logic cnv, sck, sdi, cnv_rise, cnv_fall, sck_fall, sdi_rise, sdi_fall;
   logic cs_sel, cs_start, cs_end;

   always_comb
   begin
      cnv      = q.cnv_s[1];
      sck      = q.sck_s[1];
      sdi      = q.sdi_s[1];
      cnv_rise = cnv && !q.cnv_p;
      cnv_fall = !cnv && q.cnv_p;
      sck_fall = !sck && q.sck_p;
      sdi_rise = sdi && !q.sdi_p;
      sdi_fall = !sdi && q.sdi_p;
      // chip select source follows latched mode
      cs_start = (q.mode == sar_pkg::SAR_MODE_3W) ? cnv_fall :
                 (q.mode == sar_pkg::SAR_MODE_4W) ? sdi_fall : cnv_fall;
      cs_end   = (q.mode == sar_pkg::SAR_MODE_3W) ? cnv_rise :
                 (q.mode == sar_pkg::SAR_MODE_4W) ? sdi_rise : cnv_rise;
      cs_sel   = (q.mode == sar_pkg::SAR_MODE_4W) ? !sdi : !cnv;
      fifo_take = 1'b0;

      d        = q;
      d.cnv_s  = {q.cnv_s[0], conversion_trigger_i};
      d.sck_s  = {q.sck_s[0], sclk_i};
      d.sdi_s  = {q.sdi_s[0], sdi_i};
      d.cnv_p  = cnv;
      d.sck_p  = sck;
      d.sdi_p  = sdi;
      // registered ready lags the buffer, so it drops for a cycle after each take
      d.sready = fifo_wr_ready && !(sample_valid_i && q.sready);

      unique case (q.st)
         sar_pkg::SAR_IDLE, sar_pkg::SAR_ACQ:
         begin
            if (cnv_rise)
            begin
               // mode chosen by serial-input level at trigger rise; when it is low, idle gives three-wire and acquisition gives chain
               if (sdi)
                  d.mode = sar_pkg::SAR_MODE_4W;
               else if (q.st == sar_pkg::SAR_IDLE)
                  d.mode = sar_pkg::SAR_MODE_3W;
               else
                  d.mode = sar_pkg::SAR_MODE_CHAIN;
               d.st   = sar_pkg::SAR_CONV;
               d.cnt  = CW'(CONV_CYC);
               d.busy = 1'b1;
               d.oe   = 1'b0;
            end
            else if (q.st == sar_pkg::SAR_ACQ && cs_start)
            begin
               d.st    = sar_pkg::SAR_READ;
               d.oe    = 1'b1;
               d.sdo   = q.shreg[WORD_BITS-1];
               d.bits  = BW'(WORD_BITS);
            end
         end
         sar_pkg::SAR_CONV:
         begin
            // own clock times the conversion; serial clock ignored here
            d.cnt = q.cnt - 1'b1;
            if (q.cnt == CW'(1))
            begin
               d.st   = sar_pkg::SAR_ACQ;
               d.busy = 1'b0;
               if (fifo_vld)
               begin
                  fifo_take = 1'b1;
                  d.shreg   = fifo_data;
               end
               // trigger already low outside four-wire mode: the read opens at once
               if (q.mode != sar_pkg::SAR_MODE_4W && !cnv)
               begin
                  d.st   = sar_pkg::SAR_READ;
                  d.oe   = 1'b1;
                  d.sdo  = d.shreg[WORD_BITS-1];
                  d.bits = BW'(WORD_BITS);
               end
            end
         end
         sar_pkg::SAR_READ:
         begin
            if (cnv_rise)
            begin
               // a trigger rise mid-read ends it and starts the next sample
               d.mode = sdi ? sar_pkg::SAR_MODE_4W : sar_pkg::SAR_MODE_CHAIN;
               d.st   = sar_pkg::SAR_CONV;
               d.cnt  = CW'(CONV_CYC);
               d.busy = 1'b1;
               d.oe   = 1'b0;
            end
            else if (cs_end || !cs_sel)
            begin
               d.oe = 1'b0;
               d.st = sar_pkg::SAR_ACQ;
            end
            else if (sck_fall)
            begin
               d.shreg = {q.shreg[WORD_BITS-2:0], sdi};
               d.sdo   = q.shreg[WORD_BITS-2];
               d.bits  = q.bits - 1'b1;
               if (q.bits == BW'(1) && q.mode != sar_pkg::SAR_MODE_CHAIN)
               begin
                  // word done: back to acquisition so the next trigger rise is seen
                  d.oe = 1'b0;
                  d.st = sar_pkg::SAR_ACQ;
               end
            end
         end
         default:
            d.st = sar_pkg::SAR_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         q       <= '0;
         q.st    <= sar_pkg::SAR_IDLE;
         q.mode  <= sar_pkg::SAR_MODE_3W;
         q.shreg <= `SAR_RESULT_RESET;
         q.cnv_s <= 2'b11;
         q.cnv_p <= 1'b1;
      end
      else if (ce_i)
         q <= d;
   end

   assign sdo_o          = q.sdo;
   assign sdo_oe_o       = q.oe;
   assign busy_o         = q.busy;
   assign sample_ready_o = q.sready;

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_start;
      ce_i && q.st == sar_pkg::SAR_IDLE && cnv_rise;
   endsequence

   a_conv_length : assert property (@(posedge clk_i) disable iff (reset_i)
      (q.st == sar_pkg::SAR_CONV && q.cnt == CW'(1) && ce_i) |=> !busy_o)
      else $error("conversion did not end on count");
   a_start_busy : assert property (@(posedge clk_i) disable iff (reset_i)
      s_start |=> busy_o) else $error("trigger rise did not start conversion");
   a_no_drive_conv : assert property (@(posedge clk_i) disable iff (reset_i)
      busy_o |-> !sdo_oe_o) else $error("output driven during conversion");
   a_mode_4w : assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && q.st != sar_pkg::SAR_CONV && q.st != sar_pkg::SAR_READ && cnv_rise && sdi)
      |=> q.mode == sar_pkg::SAR_MODE_4W) else $error("mode not latched");
   a_msb_first : assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(sdo_oe_o) |-> sdo_o == q.shreg[WORD_BITS-1])
      else $error("first bit not msb");
   a_release_3w : assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && q.st == sar_pkg::SAR_READ && q.mode == sar_pkg::SAR_MODE_3W && cnv_rise)
      |=> !sdo_oe_o) else $error("output not released");
   a_release_4w : assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && q.st == sar_pkg::SAR_READ && q.mode == sar_pkg::SAR_MODE_4W && sdi_rise)
      |=> !sdo_oe_o) else $error("output not released");
   a_shift_bit : assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && q.st == sar_pkg::SAR_READ && sck_fall && cs_sel && !cs_end && !cnv_rise)
      |=> sdo_o == $past(q.shreg[WORD_BITS-2])) else $error("bit not advanced");

   sequence s_restart;
      ce_i && q.st == sar_pkg::SAR_READ && cnv_rise;
   endsequence

   sequence s_read_open;
      ce_i && q.st == sar_pkg::SAR_ACQ && !cnv_rise && cs_start;
   endsequence

   sequence s_last_fall;
      ce_i && q.st == sar_pkg::SAR_READ && !cnv_rise && sck_fall && cs_sel && !cs_end
         && q.bits == BW'(1) && q.mode != sar_pkg::SAR_MODE_CHAIN;
   endsequence

   a_restart_busy : assert property (@(posedge clk_i) disable iff (reset_i)
      s_restart |=> busy_o && !sdo_oe_o) else $error("trigger rise during read ignored");
   a_read_open : assert property (@(posedge clk_i) disable iff (reset_i)
      s_read_open |=> sdo_oe_o && sdo_o == q.shreg[WORD_BITS-1])
      else $error("read did not open");
   a_word_end : assert property (@(posedge clk_i) disable iff (reset_i)
      s_last_fall |=> !sdo_oe_o) else $error("output held after last bit");
   a_chain_input : assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && q.st == sar_pkg::SAR_READ && q.mode == sar_pkg::SAR_MODE_CHAIN && sck_fall
       && cs_sel && !cs_end) |=> q.shreg[0] == $past(sdi)) else $error("chain bit not taken");
   a_conv_clock : assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && q.st == sar_pkg::SAR_CONV && q.cnt != CW'(1)) |=> q.cnt == $past(q.cnt) - 1'b1)
      else $error("conversion count stalled");
   a_busy_hold : assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && q.st == sar_pkg::SAR_CONV && q.cnt != CW'(1)) |=> busy_o)
      else $error("conversion ended early");
   a_no_lost_word : assert property (@(posedge clk_i) disable iff (reset_i)
      (ce_i && sample_valid_i && sample_ready_o) |-> fifo_wr_ready)
      else $error("offered word refused by buffer");
endmodule

// [test/sar_host_model.sv]
`timescale 1ns/100ps
module sar_host_model #(
   parameter int CONV_WAIT = 30
) (
   // clock
   input  wire logic clk_i,
   // pins toward the device
   output logic      conversion_trigger_o,
   output logic      sclk_o,
   output logic      sdi_o,
   // serial output from the device
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i,
   // level seen on the released-able line
   output logic      line_o
);
   logic last_q = 1'b0;

   // a released line shows the inverse of the last bit, never a stale copy
   always_ff @(posedge clk_i)
   begin
      if (sdo_oe_i)
         last_q <= sdo_i;
   end
   assign line_o = sdo_oe_i ? sdo_i : ~last_q;

   initial
   begin
      conversion_trigger_o = 1'b0;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end

   // one conversion and read; sclk stands still low outside the read
   task automatic frame(input sar_pkg::sar_mode_t mode, input int nbits,
                        input logic [15:0] chain_in, output logic [31:0] got);
      int i;
      got = '0;
      // keeps the minimum spacing between conversions
      repeat (200) @(posedge clk_i);
      sdi_o <= (mode == sar_pkg::SAR_MODE_4W);
      repeat (4) @(posedge clk_i);
      conversion_trigger_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      if (mode != sar_pkg::SAR_MODE_3W)
         conversion_trigger_o <= 1'b0;
      repeat (CONV_WAIT) @(posedge clk_i);
      if (mode == sar_pkg::SAR_MODE_3W)
         conversion_trigger_o <= 1'b0;
      if (mode == sar_pkg::SAR_MODE_4W)
         sdi_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      for (i = 0; i < nbits; i++)
      begin
         // capture before the falling edge replaces the bit
         @(negedge clk_i);
         got = {got[30:0], line_o};
         @(posedge clk_i);
         sclk_o <= 1'b1;
         if (mode == sar_pkg::SAR_MODE_CHAIN)
            sdi_o <= (i < 16) ? chain_in[15 - i] : 1'b0;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;
         // eight clock periods per serial clock period
         repeat (3) @(posedge clk_i);
      end
      if (mode == sar_pkg::SAR_MODE_4W && nbits < 16)
         sdi_o <= 1'b1;
   endtask
endmodule

// [test/test_sar_adc_serial_readout.sv]
`timescale 1ns/100ps
module test_sar_adc_serial_readout;
   localparam int CONV_CYC = 20;
   logic        clk_i;
   logic        reset_i;
   logic        sample_valid_i;
   logic        sample_ready_o;
   logic [15:0] sample_i;
   logic        conversion_trigger_i;
   logic        sclk_i;
   logic        sdi_i;
   logic        sdo_o;
   logic        sdo_oe_o;
   logic        busy_o;
   logic        line;
   logic [31:0] got;
   int          failures = 0;
   int          compares = 0;
   int          busy_cnt = 0;
   logic [15:0] words [5] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001, 16'h1234};

   sar_serial #(.CONV_CYC(CONV_CYC)) u_sar_serial (
      .clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
      .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .sample_i(sample_i),
      .conversion_trigger_i(conversion_trigger_i), .sclk_i(sclk_i), .sdi_i(sdi_i),
      .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .busy_o(busy_o));

   sar_host_model #(.CONV_WAIT(CONV_CYC + 10)) u_sar_host_model (
      .clk_i(clk_i), .conversion_trigger_o(conversion_trigger_i), .sclk_o(sclk_i),
      .sdi_o(sdi_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .line_o(line));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // a word offered is withdrawn on the edge that takes it
   always @(posedge clk_i)
   begin
      if (sample_valid_i && sample_ready_o)
         sample_valid_i <= 1'b0;
   end

   always @(negedge clk_i)
   begin
      if (busy_o === 1'b1)
         busy_cnt++;
      else if (busy_cnt != 0)
      begin
         check(busy_cnt, CONV_CYC);
         busy_cnt = 0;
      end
   end

   task automatic push(input logic [15:0] w);
      int n;
      @(posedge clk_i);
      sample_valid_i <= 1'b1;
      sample_i <= w;
      @(negedge clk_i);
      for (n = 0; n < 50 && sample_valid_i === 1'b1; n++)
         @(negedge clk_i);
      if (sample_valid_i === 1'b1)
         failures++;
   endtask

   // fifo takes four words, the fifth stays offered until a conversion pops
   task automatic t_fill();
      int i;
      for (i = 0; i < 4; i++)
         push(words[i]);
      @(posedge clk_i);
      sample_valid_i <= 1'b1;
      sample_i <= words[4];
      repeat (4) @(negedge clk_i);
      check({31'h0, sample_ready_o}, 32'h0);
   endtask

   task automatic t_three_wire();
      u_sar_host_model.frame(sar_pkg::SAR_MODE_3W, 16, 16'h0000, got);
      check(got, {16'h0, words[0]});
      repeat (3) @(negedge clk_i);
      check({31'h0, sdo_oe_o}, 32'h0);
   endtask

   task automatic t_four_wire();
      u_sar_host_model.frame(sar_pkg::SAR_MODE_4W, 16, 16'h0000, got);
      check(got, {16'h0, words[1]});
      repeat (3) @(negedge clk_i);
      check({31'h0, sdo_oe_o}, 32'h0);
   endtask

   // chip select rises after eight bits
   task automatic t_four_wire_abort();
      u_sar_host_model.frame(sar_pkg::SAR_MODE_4W, 8, 16'h0000, got);
      check(got, {24'h0, words[2][15:8]});
      repeat (6) @(negedge clk_i);
      check({31'h0, sdo_oe_o}, 32'h0);
   endtask

   task automatic t_chain();
      u_sar_host_model.frame(sar_pkg::SAR_MODE_CHAIN, 32, 16'ha5c3, got);
      check(got, {words[3], 16'ha5c3});
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   initial
   begin
      reset_i = 1'b1;
      sample_valid_i = 1'b0;
      sample_i = 16'h0000;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      t_fill();
      t_three_wire();
      t_four_wire();
      t_four_wire_abort();
      t_chain();
      final_report();
   end

   initial
   begin
      #200000;
      failures++;
      final_report();
   end
endmodule
